//--- rtl/host_port_pkg.sv
// Constants and types shared by the host-side bus controller
package host_port_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    // Bus timing in ns and derived cycle counts at 50 MHz
    localparam int CLK_PERIOD_NS = 20;
    localparam int STROBE_NS = 100;
    localparam int HOLD_NS = 40;
    localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    // Serial clock half period in cycles
    localparam int SCK_HALF_CYC = 2;
    localparam logic [7:0] SER_WRITE_CMD = 8'h80;
    localparam logic [7:0] SER_READ_CMD = 8'hc0;
    // Data bus bit positions reused in serial mode
    localparam int SER_CS_BIT = 3;
    localparam int SER_CLK_BIT = 5;
    localparam int SER_DIN_BIT = 6;
    localparam int SER_DOUT_BIT = 7;
    localparam logic PORT_INDEX = 1'b1;
    localparam logic PORT_DATA = 1'b0;
    localparam logic [ADDR_W-1:0] INDEX_RESET = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_STROBE = 3'b010,
        ST_HOLD = 3'b011,
        ST_SER_SHIFT = 3'b100,
        ST_SER_END = 3'b101
    } phase_e;

    typedef enum logic [1:0] {
        OP_SET_INDEX = 2'b00,
        OP_WRITE = 2'b01,
        OP_READ = 2'b10
    } op_e;
endpackage

//--- rtl/host_pins_if.sv
// Synchronised device-side status pins shared inside the controller
`timescale 1ns/1ps
`default_nettype none
interface host_pins_if;
    logic irq_n;
    logic act_n;
    logic sleep;
    logic dev_rst;
    logic dev_rst_n;
    logic [7:0] din;
    modport sync (output irq_n, act_n, sleep, dev_rst, dev_rst_n, din);
    modport core (input irq_n, act_n, sleep, dev_rst, dev_rst_n, din);
endinterface
`default_nettype wire

//--- rtl/pin_sync.sv
// Two-flop synchroniser for device pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic irq_pin_n,
    input wire logic act_pin_n,
    input wire logic sleep_pin,
    input wire logic rst_pin,
    input wire logic rst_pin_n,
    input wire logic [7:0] data_pin,
    host_pins_if.sync pins
);
    typedef struct packed {
        logic [12:0] s1;
        logic [12:0] s2;
    } sync_s;
    sync_s q_r;
    sync_s q_nxt;
    always_comb begin
        q_nxt.s1 = {irq_pin_n, act_pin_n, sleep_pin, rst_pin, rst_pin_n, data_pin};
        q_nxt.s2 = q_r.s1;
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            q_r <= '{s1: 13'h19ff, s2: 13'h19ff};
        end else begin
            q_r <= q_nxt;
        end
    end
    assign pins.irq_n = q_r.s2[12];
    assign pins.act_n = q_r.s2[11];
    assign pins.sleep = q_r.s2[10];
    assign pins.dev_rst = q_r.s2[9];
    assign pins.dev_rst_n = q_r.s2[8];
    assign pins.din = q_r.s2[7:0];
endmodule
`default_nettype wire

//--- rtl/indexed_host_bus_port.sv
// Host-side controller driving the indexed parallel or serial port of the device
`timescale 1ns/1ps
`default_nettype none
module indexed_host_bus_port
    import host_port_pkg::*;
#(
    parameter int STROBE_CYCLES = STROBE_CYC,
    parameter int HOLD_CYCLES = HOLD_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    // User command port
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire host_port_pkg::op_e cmd_op,
    input wire logic [host_port_pkg::DATA_W-1:0] cmd_data,
    input wire logic serial_mode,
    input wire logic use_read_strobe,
    output logic rsp_valid,
    output logic [host_port_pkg::DATA_W-1:0] rsp_data,
    output logic [host_port_pkg::ADDR_W-1:0] index_shadow,
    // Device pins
    output logic [7:0] data_out,
    output logic data_oe_n,
    input wire logic [7:0] data_in,
    output logic port_select_line,
    output logic cs_n,
    output logic wr_n,
    output logic rd_n,
    input wire logic irq_n,
    input wire logic activity_out_n,
    input wire logic sleep_indicator,
    input wire logic dev_rst,
    input wire logic dev_rst_n,
    output logic ext_reset_in,
    input wire logic reset_device,
    output logic usb_drive_enable,
    input wire logic usb_enable_req,
    // Status to user
    output logic irq_pending,
    output logic usb_active,
    output logic device_asleep,
    output logic device_in_reset
);
    import host_port_pkg::*;

    host_pins_if pins();

    pin_sync u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .irq_pin_n(irq_n),
        .act_pin_n(activity_out_n),
        .sleep_pin(sleep_indicator),
        .rst_pin(dev_rst),
        .rst_pin_n(dev_rst_n),
        .data_pin(data_in),
        .pins(pins)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        phase_e phase;
        op_e op;
        logic [CNT_W-1:0] cnt;
        logic [3:0] bits;
        logic [15:0] shreg;
        logic [7:0] dout;
        logic oe_n;
        logic sel;
        logic cs_n;
        logic wr_n;
        logic rd_n;
        logic sck;
        logic scs_n;
        logic [7:0] rdata;
        logic rvalid;
        logic [ADDR_W-1:0] index;
        logic ser;
    } ctl_s;

    ctl_s s_r;
    ctl_s s_nxt;

    function automatic logic [ADDR_W-1:0] next_index(input logic [ADDR_W-1:0] idx);
        next_index = idx + 8'h01;
    endfunction

    always_comb begin
        s_nxt = s_r;
        s_nxt.rvalid = 1'b0;
        unique case (s_r.phase)
            ST_IDLE: begin
                s_nxt.oe_n = 1'b1;
                if (cmd_valid && !pins.dev_rst) begin
                    s_nxt.op = cmd_op;
                    s_nxt.ser = serial_mode;
                    s_nxt.cnt = '0;
                    s_nxt.dout = cmd_data;
                    if (serial_mode) begin
                        // Serial frame: command byte then one data byte
                        s_nxt.scs_n = 1'b0;
                        s_nxt.bits = 4'hf;
                        s_nxt.sck = 1'b0;
                        s_nxt.shreg = {(cmd_op == OP_READ) ? SER_READ_CMD : SER_WRITE_CMD,
                            (cmd_op == OP_READ) ? 8'h00 : cmd_data};
                        s_nxt.phase = ST_SER_SHIFT;
                    end else begin
                        s_nxt.sel = (cmd_op == OP_SET_INDEX) ? PORT_INDEX : PORT_DATA;
                        s_nxt.oe_n = (cmd_op == OP_READ);
                        s_nxt.phase = ST_SETUP;
                    end
                end
            end
            ST_SETUP: begin
                s_nxt.cs_n = 1'b0;
                if (s_r.op == OP_READ) begin
                    s_nxt.rd_n = !use_read_strobe;
                end else begin
                    s_nxt.wr_n = 1'b0;
                end
                s_nxt.phase = ST_STROBE;
            end
            ST_STROBE: begin
                s_nxt.cnt = s_r.cnt + 4'h1;
                if (32'(s_r.cnt) + 1 >= STROBE_CYCLES) begin
                    if (s_r.op == OP_READ) begin
                        s_nxt.rdata = pins.din;
                    end
                    s_nxt.wr_n = 1'b1;
                    s_nxt.rd_n = 1'b1;
                    s_nxt.cs_n = 1'b1;
                    s_nxt.cnt = '0;
                    s_nxt.phase = ST_HOLD;
                end
            end
            ST_HOLD: begin
                s_nxt.cnt = s_r.cnt + 4'h1;
                if (32'(s_r.cnt) + 1 >= HOLD_CYCLES) begin
                    s_nxt.oe_n = 1'b1;
                    s_nxt.phase = ST_SER_END;
                end
            end
            ST_SER_SHIFT: begin
                s_nxt.cnt = s_r.cnt + 4'h1;
                if (32'(s_r.cnt) + 1 >= SCK_HALF_CYC) begin
                    s_nxt.cnt = '0;
                    s_nxt.sck = !s_r.sck;
                    if (s_r.sck) begin
                        s_nxt.shreg = {s_r.shreg[14:0], 1'b0};
                        if (s_r.bits == 4'h0) begin
                            s_nxt.scs_n = 1'b1;
                            s_nxt.phase = ST_SER_END;
                        end else begin
                            s_nxt.bits = s_r.bits - 4'h1;
                        end
                    end else if (s_r.op == OP_READ && s_r.bits < 4'h8) begin
                        // Sample device output; tied lines also work
                        s_nxt.rdata = {s_r.rdata[6:0], pins.din[SER_DOUT_BIT]};
                    end
                end
            end
            ST_SER_END: begin
                s_nxt.phase = ST_IDLE;
                s_nxt.rvalid = (s_r.op == OP_READ);
                if (s_r.op == OP_SET_INDEX) begin
                    s_nxt.index = s_r.dout;
                end else begin
                    s_nxt.index = next_index(s_r.index);
                end
            end
            default: s_nxt.phase = ST_IDLE;
        endcase
        if (pins.dev_rst || !pins.dev_rst_n) begin
            s_nxt.index = INDEX_RESET;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_r <= '{phase: ST_IDLE, op: OP_SET_INDEX, cnt: '0, bits: '0, shreg: '0,
                dout: '0, oe_n: 1'b1, sel: 1'b1, cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1,
                sck: 1'b0, scs_n: 1'b1, rdata: '0, rvalid: 1'b0, index: INDEX_RESET,
                ser: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    always_comb begin
        data_out = s_r.dout;
        data_oe_n = s_r.oe_n;
        if (s_r.ser) begin
            data_out = 8'hff;
            data_out[SER_CS_BIT] = s_r.scs_n;
            data_out[SER_CLK_BIT] = s_r.sck;
            data_out[SER_DIN_BIT] = s_r.shreg[15];
            data_oe_n = (s_r.phase == ST_IDLE);
        end
    end
    assign port_select_line = s_r.sel;
    assign cs_n = s_r.cs_n;
    assign wr_n = s_r.wr_n;
    assign rd_n = s_r.rd_n;
    assign cmd_ready = (s_r.phase == ST_IDLE) && !pins.dev_rst;
    assign rsp_valid = s_r.rvalid;
    assign rsp_data = s_r.rdata;
    assign index_shadow = s_r.index;
    assign ext_reset_in = reset_device;
    assign usb_drive_enable = usb_enable_req;
    assign irq_pending = !pins.irq_n;
    assign usb_active = !pins.act_n;
    assign device_asleep = pins.sleep;
    assign device_in_reset = pins.dev_rst || !pins.dev_rst_n;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    strobe_excl_a: assert property (@(posedge core_clk) disable iff (rst)
        !(!wr_n && !rd_n)) else $error("both strobes low");
    strobe_cs_a: assert property (@(posedge core_clk) disable iff (rst)
        (!wr_n || !rd_n) |-> !cs_n) else $error("strobe without select");
    read_release_a: assert property (@(posedge core_clk) disable iff (rst)
        !rd_n |-> data_oe_n) else $error("bus driven during read");
    write_drive_a: assert property (@(posedge core_clk) disable iff (rst)
        !wr_n |-> !data_oe_n && $stable(data_out)) else $error("write data not held");
    index_sel_a: assert property (@(posedge core_clk) disable iff (rst || s_r.ser)
        (!cs_n && s_r.op == OP_SET_INDEX) |-> port_select_line) else $error("index select low");
    data_sel_a: assert property (@(posedge core_clk) disable iff (rst || s_r.ser)
        (!cs_n && s_r.op != OP_SET_INDEX) |-> !port_select_line) else $error("data select high");
    index_inc_a: assert property (@(posedge core_clk) disable iff (rst)
        (s_r.phase == ST_SER_END && s_r.op != OP_SET_INDEX && !device_in_reset)
        |=> index_shadow == $past(index_shadow) + 8'h01) else $error("index not advanced");
    index_clr_a: assert property (@(posedge core_clk) disable iff (rst)
        device_in_reset |=> index_shadow == INDEX_RESET) else $error("index not cleared");
    ser_cs_a: assert property (@(posedge core_clk) disable iff (rst)
        (s_r.phase == ST_SER_SHIFT) |-> !data_out[SER_CS_BIT] && !data_oe_n)
        else $error("serial select high in frame");
    cmd_write_c: cover property (@(posedge core_clk) !wr_n && !port_select_line);
    cmd_read_c: cover property (@(posedge core_clk) rsp_valid);
    cmd_serial_c: cover property (@(posedge core_clk) s_r.phase == ST_SER_END && s_r.ser);
    index_wrap_c: cover property (@(posedge core_clk) index_shadow == 8'hff ##[1:50] index_shadow == 8'h00);
endmodule
`default_nettype wire

//--- tb/device_model.sv
// Behavioural model of the indexed-port device seen by the controller
`timescale 1ns/1ps
`default_nettype none
module device_model (
    input wire logic core_clk,
    input wire logic por,
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic port_select_line,
    input wire logic [7:0] bus,
    input wire logic ext_reset_in,
    input wire logic irq_req,
    input wire logic act_req,
    input wire logic sleep_req,
    output logic [7:0] dev_q,
    output logic dev_oe,
    output logic dev_rst,
    output logic dev_rst_n,
    output logic irq_n,
    output logic activity_out_n,
    output logic sleep_indicator,
    output logic [7:0] idx
);
    // ----------------------------------------
    // Pins and register space
    // ----------------------------------------
    logic [7:0] mem [256];
    logic wr_act_r;
    logic rd_act_r;
    logic sel_r;
    logic [7:0] wdata_r;
    logic wr_now;
    assign wr_now = ~cs_n & ~wr_n;
    assign dev_oe = ~cs_n & ~rd_n;
    assign dev_q = mem[idx];
    assign dev_rst = por | ext_reset_in;
    assign dev_rst_n = ~dev_rst;
    assign irq_n = irq_req ? 1'b0 : 1'b1;
    assign activity_out_n = act_req ? 1'b0 : 1'b1;
    assign sleep_indicator = sleep_req;
    always_ff @(posedge core_clk) begin
        wr_act_r <= wr_now;
        rd_act_r <= dev_oe;
        if (wr_now) begin
            wdata_r <= bus;
            sel_r <= port_select_line;
        end
        if (dev_rst) begin
            idx <= 8'h00;
        end else if (wr_act_r && !wr_now) begin
            if (sel_r) begin
                idx <= wdata_r;
            end else begin
                mem[idx] <= wdata_r;
                idx <= idx + 8'h01;
            end
        end else if (rd_act_r && !dev_oe) begin
            idx <= idx + 8'h01;
        end
    end
endmodule
`default_nettype wire

//--- tb/indexed_host_bus_port_tb.sv
// Self-checking bench for the indexed host bus controller
`timescale 1ns/1ps
`default_nettype none
module indexed_host_bus_port_tb;
    import host_port_pkg::*;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    op_e cmd_op = OP_WRITE;
    logic [7:0] cmd_data = 8'h00;
    logic serial_mode = 1'b0;
    logic use_read_strobe = 1'b1;
    logic reset_device = 1'b0;
    logic usb_enable_req = 1'b0;
    logic irq_req = 1'b0;
    logic act_req = 1'b0;
    logic sleep_req = 1'b0;
    logic cmd_ready, rsp_valid, data_oe_n, port_select_line, cs_n, wr_n, rd_n;
    logic irq_n, activity_out_n, sleep_indicator, dev_rst, dev_rst_n, ext_reset_in;
    logic usb_drive_enable, irq_pending, usb_active, device_asleep, device_in_reset;
    logic dev_oe;
    logic [7:0] rsp_data, index_shadow, data_out, dev_q, idx, r;
    wire [7:0] bus = !data_oe_n ? data_out : dev_oe ? dev_q : 8'hff;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    always #10 core_clk = ~core_clk;
    indexed_host_bus_port DUT (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
        .serial_mode(serial_mode), .use_read_strobe(use_read_strobe),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .index_shadow(index_shadow),
        .data_out(data_out), .data_oe_n(data_oe_n), .data_in(bus),
        .port_select_line(port_select_line), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
        .irq_n(irq_n), .activity_out_n(activity_out_n), .sleep_indicator(sleep_indicator),
        .dev_rst(dev_rst), .dev_rst_n(dev_rst_n), .ext_reset_in(ext_reset_in),
        .reset_device(reset_device), .usb_drive_enable(usb_drive_enable),
        .usb_enable_req(usb_enable_req), .irq_pending(irq_pending),
        .usb_active(usb_active), .device_asleep(device_asleep),
        .device_in_reset(device_in_reset));
    device_model partner (.core_clk(core_clk), .por(rst), .cs_n(cs_n), .wr_n(wr_n),
        .rd_n(rd_n), .port_select_line(port_select_line), .bus(bus),
        .ext_reset_in(ext_reset_in), .irq_req(irq_req), .act_req(act_req),
        .sleep_req(sleep_req), .dev_q(dev_q), .dev_oe(dev_oe), .dev_rst(dev_rst),
        .dev_rst_n(dev_rst_n), .irq_n(irq_n), .activity_out_n(activity_out_n),
        .sleep_indicator(sleep_indicator), .idx(idx));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        if (n_mismatch == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic do_cmd(input op_e op, input logic [7:0] d, output logic [7:0] rd);
        int n;
        n = 0;
        rd = 8'hxx;
        do begin
            @(negedge core_clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 200);
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_data <= d;
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
            if (rsp_valid === 1'b1) rd = rsp_data;
        end while (cmd_ready !== 1'b1 && n < 200);
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    always @(negedge core_clk) begin
        if (!rst && data_oe_n === 1'b0 && dev_oe === 1'b1) begin
            n_mismatch++;
            $display("Error bus contention expected 0 seen 1");
        end
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_idle();
        chk("idle strobes", 8'h0f, {4'h0, port_select_line, cs_n, wr_n, rd_n});
        chk("idle bus drive", 8'h01, {7'h0, data_oe_n});
        chk("shadow after reset", 8'h00, index_shadow);
    endtask
    task automatic t_write_read();
        do_cmd(OP_SET_INDEX, 8'h10, r);
        chk("device index", 8'h10, idx);
        for (int i = 0; i < 3; i++) do_cmd(OP_WRITE, 8'h5a + 8'(i), r);
        chk("device index", 8'h13, idx);
        chk("shadow", 8'h13, index_shadow);
        do_cmd(OP_SET_INDEX, 8'h10, r);
        for (int i = 0; i < 3; i++) begin
            do_cmd(OP_READ, 8'h00, r);
            chk("read data", 8'h5a + 8'(i), r);
        end
    endtask
    task automatic t_wrap();
        do_cmd(OP_SET_INDEX, 8'hff, r);
        do_cmd(OP_WRITE, 8'hc3, r);
        chk("device index wrap", 8'h00, idx);
        chk("shadow wrap", 8'h00, index_shadow);
        do_cmd(OP_SET_INDEX, 8'hff, r);
        do_cmd(OP_READ, 8'h00, r);
        chk("top byte", 8'hc3, r);
    endtask
    task automatic t_no_read_strobe();
        @(posedge core_clk) use_read_strobe <= 1'b0;
        do_cmd(OP_SET_INDEX, 8'h20, r);
        do_cmd(OP_WRITE, 8'h77, r);
        @(posedge core_clk) use_read_strobe <= 1'b1;
        do_cmd(OP_SET_INDEX, 8'h20, r);
        do_cmd(OP_READ, 8'h00, r);
        chk("write without read strobe", 8'h77, r);
    endtask
    task automatic t_status(input logic v);
        @(posedge core_clk);
        irq_req <= v;
        act_req <= ~v;
        sleep_req <= v;
        usb_enable_req <= v;
        repeat (3) @(negedge core_clk);
        chk("irq pending", {7'h0, v}, {7'h0, irq_pending});
        chk("usb active", {7'h0, ~v}, {7'h0, usb_active});
        chk("asleep", {7'h0, v}, {7'h0, device_asleep});
        chk("usb enable", {7'h0, v}, {7'h0, usb_drive_enable});
    endtask
    task automatic t_dev_reset();
        do_cmd(OP_SET_INDEX, 8'h40, r);
        @(posedge core_clk) reset_device <= 1'b1;
        repeat (3) @(negedge core_clk);
        chk("reset pin", 8'h01, {7'h0, ext_reset_in});
        chk("in reset", 8'h01, {7'h0, device_in_reset});
        chk("ready in reset", 8'h00, {7'h0, cmd_ready});
        @(posedge core_clk) reset_device <= 1'b0;
        repeat (4) @(negedge core_clk);
        chk("out of reset", 8'h00, {7'h0, device_in_reset});
        chk("shadow cleared", 8'h00, index_shadow);
        do_cmd(OP_WRITE, 8'h99, r);
        chk("device index", 8'h01, idx);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        repeat (4) @(negedge core_clk);
        t_idle();
        t_write_read();
        t_wrap();
        t_no_read_strobe();
        t_status(1'b1);
        t_status(1'b0);
        t_dev_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
